// *** rtl/lech_consts.svh ***
/*
 * Constants for the lane 5/6 error counter hold configuration bank:
 * register offsets, field positions, reset values and counter limits.
 * Assumes the register port carries a 12-bit address and 8-bit data.
 */
`ifndef LECH_CONSTS_SVH
`define LECH_CONSTS_SVH

`define LECH_ADDR_W          12
`define LECH_DATA_W          8
`define LECH_LANE5_HOLD_OFS  12'h48d
`define LECH_LANE6_HOLD_OFS  12'h48e
`define LECH_HOLD_MSB        2
`define LECH_HOLD_LSB        0
`define LECH_HOLD_RESET      3'h7
`define LECH_RSVD_W          5
`define LECH_RDATA_RESET     8'h00
`define LECH_COUNT_W         8
`define LECH_COUNT_RESET     8'h00

`endif

// *** rtl/lech_pkg.sv ***
/*
 * Types shared by the lane 5/6 error counter hold configuration bank.
 * Assumes lech_consts.svh is on the include path.
 */
`include "lech_consts.svh"

package lech_pkg;

    // One bit per error kind; field order follows the hold-enable bit order
    typedef struct packed {
        logic unexpected_control_char_error;
        logic code_missing_error;
        logic bad_disparity_error;
    } lech_err_type;

    // The three 8-bit error counts of one lane, same order as above
    typedef struct packed {
        logic [`LECH_COUNT_W-1:0] unexpected_control_char_error;
        logic [`LECH_COUNT_W-1:0] code_missing_error;
        logic [`LECH_COUNT_W-1:0] bad_disparity_error;
    } lech_cnt_type;

    // Whole register state of the bank
    typedef struct packed {
        lech_err_type             lane5_count_hold_enable;
        lech_err_type             lane6_count_hold_enable;
        logic [`LECH_DATA_W-1:0]  rdata;
    } lech_regs_type;

endpackage

// *** rtl/lech_err_counter.sv ***
/*
 * One lane error counter that either saturates at all ones or rolls over.
 * Assumes error pulses and clears are synchronous to CORE_CLK.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lech_consts.svh"

module lech_err_counter #(
    parameter int COUNT_W = `LECH_COUNT_W
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               hold_enable,
    input  wire logic               error_event,
    input  wire logic               count_clear,
    output logic [COUNT_W-1:0]      count
);
    import lech_pkg::*;

    typedef struct packed {
        logic [COUNT_W-1:0] count;
    } lech_ctr_state_type;

    lech_ctr_state_type state;
    lech_ctr_state_type next_state;

    localparam logic [COUNT_W-1:0] TERMINAL = {COUNT_W{1'b1}};

    generate
        if (COUNT_W < 2) begin : g_bad_width
            $error("lech_err_counter: COUNT_W must be at least 2");
        end
    endgenerate

    // A clear coinciding with an error keeps that error, so the count restarts at one
    always_comb begin
        next_state = state;
        if (count_clear) begin
            next_state.count = error_event ? COUNT_W'(1) : '0;
        end else if (error_event) begin
            if (hold_enable && state.count == TERMINAL) begin
                next_state.count = TERMINAL;
            end else begin
                next_state.count = state.count + COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign count = state.count;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Once saturated with hold set, further errors leave the count alone
    sequence at_terminal_held_s;
        hold_enable && state.count == TERMINAL && !count_clear;
    endsequence

    hold_saturate_a: assert property (at_terminal_held_s ##0 error_event |=> count == TERMINAL)
        else $error("held counter left its terminal value");

    hold_keeps_a: assert property (at_terminal_held_s [*2] |=> count == TERMINAL)
        else $error("held counter changed without a clear");

    wrap_over_a: assert property (!hold_enable && !count_clear && error_event
                                  && count == TERMINAL |=> count == '0)
        else $error("counter without hold did not roll over");

    count_step_a: assert property (!count_clear && error_event && count != TERMINAL
                                   |=> count == $past(count) + COUNT_W'(1))
        else $error("counter did not advance by one on an error");

    clear_zero_a: assert property (count_clear && !error_event |=> count == '0)
        else $error("clear did not zero the counter");

endmodule

`default_nettype wire

// *** rtl/lech_top.sv ***
/*
 * Hold-enable configuration registers for the lane 5 and lane 6 error
 * counters of the quad_byte_deframer, plus the six counters they steer.
 * Assumes a register port from the serial control decoder, one access
 * per cycle, 12-bit address, 8-bit data, all synchronous to CORE_CLK.
 */
//
// How it works
// - With hold set, a counter reaching 0xff stays there until software clears it.
// - With hold clear, a counter rolls over past 0xff.
// - Hold bit 2 unexpected control char, bit 1 code missing, bit 0 disparity.
// - Each lane has its own writable three-bit hold field, reset value 0x7.
`timescale 1ns/100ps
`default_nettype none
`include "lech_consts.svh"

module lech_top #(
    parameter int LANES   = 2,
    parameter int COUNT_W = `LECH_COUNT_W
) (
    input  wire logic                       CORE_CLK,
    input  wire logic                       NRST,
    input  wire logic                       REG_WR,
    input  wire logic                       REG_RD,
    input  wire logic [`LECH_ADDR_W-1:0]    REG_ADDR,
    input  wire logic [`LECH_DATA_W-1:0]    REG_WDATA,
    output logic      [`LECH_DATA_W-1:0]    REG_RDATA,
    input  wire lech_pkg::lech_err_type     ERR_EVENT [LANES],
    input  wire lech_pkg::lech_err_type     COUNT_CLEAR [LANES],
    output lech_pkg::lech_cnt_type          ERR_COUNT [LANES]
);
    import lech_pkg::*;

    lech_regs_type state;
    lech_regs_type next_state;

    logic [2:0] hold_bits [LANES];
    logic [2:0] event_bits [LANES];
    logic [2:0] clear_bits [LANES];
    logic [2:0][COUNT_W-1:0] cnt_bits [LANES];

    generate
        if (LANES != 2) begin : g_bad_lanes
            $error("lech_top: only lanes 5 and 6 are served, LANES must be 2");
        end
        if (COUNT_W != `LECH_COUNT_W) begin : g_bad_count
            $error("lech_top: COUNT_W must match the package count width");
        end
    endgenerate

    // Address match, shared by the write and the read decode
    function automatic logic addr_hit(input logic [`LECH_ADDR_W-1:0] addr,
                                      input logic [`LECH_ADDR_W-1:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    // Read value of one hold register; the reserved bits are forced to zero
    function automatic logic [`LECH_DATA_W-1:0] hold_read(input lech_err_type f);
        hold_read = {{`LECH_RSVD_W{1'b0}}, f};
    endfunction

    // Register write and read decode; unmapped reads answer zero.
    // Writes are not gated by soft reset: keeping them quiet in operation is up to software.
    always_comb begin
        next_state = state;
        if (REG_WR && addr_hit(REG_ADDR, `LECH_LANE5_HOLD_OFS)) begin
            next_state.lane5_count_hold_enable =
                lech_err_type'(REG_WDATA[`LECH_HOLD_MSB:`LECH_HOLD_LSB]);
        end
        if (REG_WR && addr_hit(REG_ADDR, `LECH_LANE6_HOLD_OFS)) begin
            next_state.lane6_count_hold_enable =
                lech_err_type'(REG_WDATA[`LECH_HOLD_MSB:`LECH_HOLD_LSB]);
        end
        if (REG_RD) begin
            if (addr_hit(REG_ADDR, `LECH_LANE5_HOLD_OFS)) begin
                next_state.rdata = hold_read(state.lane5_count_hold_enable);
            end else if (addr_hit(REG_ADDR, `LECH_LANE6_HOLD_OFS)) begin
                next_state.rdata = hold_read(state.lane6_count_hold_enable);
            end else begin
                next_state.rdata = `LECH_RDATA_RESET;
            end
        end
    end

    // Both hold fields come up set so every counter saturates by default
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            state.lane5_count_hold_enable <= lech_err_type'(`LECH_HOLD_RESET);
            state.lane6_count_hold_enable <= lech_err_type'(`LECH_HOLD_RESET);
            state.rdata                   <= `LECH_RDATA_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign REG_RDATA    = state.rdata;
    assign hold_bits[0] = state.lane5_count_hold_enable;
    assign hold_bits[1] = state.lane6_count_hold_enable;

    // Bit k of a hold field steers counter k of the lane; struct order keeps 2/1/0 aligned
    genvar g;
    genvar k;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign event_bits[g] = ERR_EVENT[g];
            assign clear_bits[g] = COUNT_CLEAR[g];
            assign ERR_COUNT[g]  = lech_cnt_type'(cnt_bits[g]);
            for (k = 0; k < 3; k++) begin : g_kind
                lech_err_counter #(
                    .COUNT_W     (COUNT_W)
                ) u_ctr (
                    .clk         (CORE_CLK),
                    .nrst        (NRST),
                    .hold_enable (hold_bits[g][k]),
                    .error_event (event_bits[g][k]),
                    .count_clear (clear_bits[g][k]),
                    .count       (cnt_bits[g][k])
                );
            end
        end
    endgenerate

    default clocking cb @(posedge CORE_CLK); endclocking

    // Fields stand at 0x7 the first cycle after reset is released
    reset_value_a: assert property (disable iff (1'b0) !NRST |=>
            state.lane5_count_hold_enable == 3'h7
            && state.lane6_count_hold_enable == 3'h7)
        else $error("hold fields did not reset to 0x7");

    write_lane5_a: assert property (disable iff (!NRST)
            REG_WR && REG_ADDR == `LECH_LANE5_HOLD_OFS |=>
            state.lane5_count_hold_enable == $past(REG_WDATA[2:0]))
        else $error("lane 5 hold write not stored");

    write_separate_a: assert property (disable iff (!NRST)
            REG_WR && REG_ADDR == `LECH_LANE5_HOLD_OFS |=> $stable(state.lane6_count_hold_enable))
        else $error("lane 5 write disturbed lane 6");

    reserved_zero_a: assert property (disable iff (!NRST)
            REG_RD && (REG_ADDR == `LECH_LANE5_HOLD_OFS || REG_ADDR == `LECH_LANE6_HOLD_OFS)
            |=> REG_RDATA[7:3] == 5'h00)
        else $error("reserved bits read nonzero");

    read_back_a: assert property (disable iff (!NRST)
            REG_RD && !REG_WR && REG_ADDR == `LECH_LANE6_HOLD_OFS
            |=> REG_RDATA[2:0] == state.lane6_count_hold_enable)
        else $error("lane 6 read-back mismatch");

    bit_map_a: assert property (disable iff (!NRST)
            !state.lane6_count_hold_enable.unexpected_control_char_error
            && ERR_EVENT[1].unexpected_control_char_error
            && !COUNT_CLEAR[1].unexpected_control_char_error
            && ERR_COUNT[1].unexpected_control_char_error == 8'hff
            |=> ERR_COUNT[1].unexpected_control_char_error == 8'h00)
        else $error("hold bit 2 does not steer the unexpected control char counter");

endmodule

`default_nettype wire

// *** dv/lane_error_count_hold_config_tb.sv ***
/*
 * Self-checking bench for the lane 5/6 error counter hold bank.
 * Assumes lech_pkg is compiled first and rtl/ is on the include path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lech_consts.svh"

module lane_error_count_hold_config_tb;
    import lech_pkg::*;

    logic                    core_clk = 1'b0;
    logic                    nrst     = 1'b0;
    logic                    wr       = 1'b0;
    logic                    rd       = 1'b0;
    logic [`LECH_ADDR_W-1:0] addr     = '0;
    logic [`LECH_DATA_W-1:0] wdata    = '0;
    logic [`LECH_DATA_W-1:0] rdata;
    lech_err_type            err_event [2];
    lech_err_type            count_clear [2];
    lech_cnt_type            err_count [2];
    logic [48:0]             notes [$];
    logic [7:0]              model [2][3];
    logic [2:0]              hold [2];
    logic [2:0]              h;
    logic                    cnt_req  = 1'b0;
    logic                    rd_seen  = 1'b0;
    logic                    cnt_seen = 1'b0;
    int                      failures = 0;
    int                      check_count = 0;
    int                      seed = 32'h7719;

    lech_top lech_top_i (
        .CORE_CLK    (core_clk),
        .NRST        (nrst),
        .REG_WR      (wr),
        .REG_RD      (rd),
        .REG_ADDR    (addr),
        .REG_WDATA   (wdata),
        .REG_RDATA   (rdata),
        .ERR_EVENT   (err_event),
        .COUNT_CLEAR (count_clear),
        .ERR_COUNT   (err_count)
    );

    // 100 MHz core clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Results show one cycle after their strobe, so notes pop in issue order
    always @(posedge core_clk) begin
        rd_seen  <= rd;
        cnt_seen <= cnt_req;
    end

    always @(negedge core_clk) begin
        if (rd_seen || cnt_seen) begin
            if (notes.size() == 0) begin
                failures++;
                $display("unexpected result: expected none, seen one");
            end else begin
                if (notes[0][48])
                    check("lane counts", {err_count[1], err_count[0]}, notes[0][47:0]);
                else
                    check("read data", {40'h0, rdata}, notes[0][47:0]);
                void'(notes.pop_front());
            end
        end
    end

    task automatic idle();
        @(negedge core_clk);
        wr = 1'b0;
        rd = 1'b0;
        cnt_req = 1'b0;
        err_event = '{default: '0};
        count_clear = '{default: '0};
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        rd = 1'b0;
        wr = 1'b1;
        addr = a;
        wdata = d;
    endtask

    task automatic reg_read(input logic [11:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        wr = 1'b0;
        rd = 1'b1;
        addr = a;
        notes.push_back({1'b0, 40'h0, exp});
    endtask

    // One cycle of counter stimulus; the model saturates only where hold is set
    task automatic tick(input logic [5:0] ev, input logic [5:0] cl);
        @(negedge core_clk);
        for (int l = 0; l < 2; l++) begin
            err_event[l] = ev[3*l +: 3];
            count_clear[l] = cl[3*l +: 3];
            for (int b = 0; b < 3; b++) begin
                if (cl[3*l+b])
                    model[l][b] = {7'h00, ev[3*l+b]};
                else if (ev[3*l+b] && !(hold[l][b] && model[l][b] == 8'hff))
                    model[l][b] = model[l][b] + 8'h01;
            end
        end
        cnt_req = 1'b1;
        notes.push_back({1'b1, model[1][2], model[1][1], model[1][0],
                         model[0][2], model[0][1], model[0][0]});
    endtask

    initial begin
        err_event = '{default: '0};
        count_clear = '{default: '0};
        hold = '{3'h7, 3'h7};
        model = '{default: '{default: 8'h00}};
        repeat (16) @(negedge core_clk);
        nrst = 1'b1;
        // Reset values, reserved bits, unmapped neighbours
        reg_read(12'h48d, 8'h07);
        reg_read(12'h48e, 8'h07);
        reg_write(12'h48d, 8'hf8);
        reg_read(12'h48d, 8'h00);
        reg_read(12'h48e, 8'h07);
        reg_read(12'h48c, 8'h00);
        reg_read(12'h48f, 8'h00);
        // Each hold bit sees both settings across the two rounds
        h = 3'($random(seed));
        for (int r = 0; r < 2; r++) begin
            hold[r] = h;
            hold[1-r] = ~h;
            idle();
            // Settings change only while no errors arrive
            reg_write(12'h48d, {5'($random(seed)), hold[0]});
            reg_write(12'h48e, {5'($random(seed)), hold[1]});
            reg_read(12'h48d, {5'h00, hold[0]});
            reg_read(12'h48e, {5'h00, hold[1]});
            idle();
            tick(6'h3f, 6'h3f);
            // First 451 ticks run clear-free and push every counter past 0xff; later ticks add random clears
            for (int i = 0; i < 700; i++)
                tick(6'($random(seed) | $random(seed)),
                     (i > 450 && $random(seed) % 16 == 0) ? 6'($random(seed)) : 6'h00);
        end
        // Second reset in mid-run brings back defaults and zero counts
        idle();
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        hold = '{3'h7, 3'h7};
        model = '{default: '{default: 8'h00}};
        reg_read(12'h48d, 8'h07);
        reg_read(12'h48e, 8'h07);
        idle();
        tick(6'h00, 6'h00);
        idle();
        for (int i = 0; i < 8 && notes.size() != 0; i++)
            @(negedge core_clk);
        if (notes.size() != 0)
            failures++;
        end_of_test();
    end

    // Watchdog against a hang
    initial begin
        #200us;
        failures++;
        end_of_test();
    end
endmodule

`default_nettype wire
